/* File: core/pbcs_defines.svh */
// Offsets, field positions, reset values and masks of the command/status block.
// Assumes inclusion by bare name from the package and the block module.
// Function
// - Command bits 15 to 11 always read as zero.
// - The legacy interrupt disable bit 10 is read-only zero.
// - The back-to-back enable bit 9 always reads as zero.
// - Bit 8 is read/write, resets to 0, and allows error messages for secondary system errors.
// - The stepping control bit 7 is hardwired to zero.
// - Bit 6 is read/write, resets to 0, and allows a poisoned completion or forwarded poisoned write to set status bit 8.
// - A poisoned packet is forwarded to the secondary bus with bad parity regardless of bit 6.
// - The palette snoop bit 5 always reads as zero.
// - Bit 4 is read/write, resets to 0, and promotes memory writes to write-and-invalidate.
// - The special-cycle bit 3 always reads as zero.
// - Bit 2 is read/write, resets to 0, and allows initiating upstream and forwarding upward.
// - With bit 2 clear only error messages are initiated upstream and secondary requests get no response.
// - Bit 1 is read/write, resets to 0; clear means memory requests get unsupported-request.
// - Bit 0 is read/write, resets to 0; clear means I/O requests get unsupported-request.
// - Status bit 8 sets only with bit 6 set on a poisoned completion or poisoned write.
// - Status bit 14 sets when an error message is sent while bit 8 is set.
`ifndef PBCS_DEFINES_SVH
`define PBCS_DEFINES_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define PBCS_OFS_COMMAND 12'h004
`define PBCS_OFS_STATUS 12'h006

// ----------------------------------------------------------------
// Command fields
// ----------------------------------------------------------------
`define PBCS_CMD_IO 0
`define PBCS_CMD_MEM 1
`define PBCS_CMD_MASTER 2
`define PBCS_CMD_WINV 4
`define PBCS_CMD_PARITY 6
`define PBCS_CMD_SYSERR 8
`define PBCS_CMD_RW_MASK 16'h0157
`define PBCS_CMD_RESET 16'h0000

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define PBCS_STS_MPAR 8
`define PBCS_STS_SIGSERR 14
`define PBCS_STS_DETPAR 15
`define PBCS_STS_FIXED 16'h0010
`define PBCS_STS_RW1C_MASK 16'hc100
`define PBCS_STS_RESET 16'h0010

`endif

/* File: core/pbcs_pkg.sv */
// Types shared by the command/status block.
// Assumes pbcs_defines.svh is on the include path.
`default_nettype none
`include "pbcs_defines.svh"

package pbcs_pkg;
    typedef logic [15:0] pbcs_word_type;
    typedef logic [11:0] pbcs_addr_type;
endpackage

`default_nettype wire

/* File: core/pbcs_command_status.sv */
// Command and status registers of the bridge function, with request gating.
// Assumes a configuration access port on clk_sys and a raw secondary error pin.
`timescale 1ns/1ps
`default_nettype none
`include "pbcs_defines.svh"

module pbcs_command_status (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // Configuration access
    input  wire logic                   cfgWrite,
    input  wire logic                   cfgRead,
    input  wire pbcs_pkg::pbcs_addr_type cfgAddr,
    input  wire logic [3:0]             cfgByteEn,
    input  wire logic [31:0]            cfgWriteData,
    output logic [31:0]                 cfgReadData,
    output logic                        cfgReadValid,
    // Downstream requests from the primary link
    input  wire logic                   dnReqValid,
    input  wire logic                   dnReqIsIo,
    input  wire logic                   dnReqIsWrite,
    input  wire logic                   dnReqPoisoned,
    output logic                        dnForward,
    output logic                        dnUnsupported,
    output logic                        dnPromoteWinv,
    output logic                        dnBadParity,
    // Completions from the primary link
    input  wire logic                   cplValid,
    input  wire logic                   cplPoisoned,
    output logic                        cplBadParity,
    // Secondary bus side
    input  wire logic                   serr_n,
    input  wire logic                   secReqValid,
    output logic                        secForward,
    output logic                        secIgnore,
    output logic                        errMsgSend,
    // Command levels
    output logic                        upInitAllow
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // True when the byte address falls inside the command/status dword.
    function automatic logic hitsWord(input pbcs_pkg::pbcs_addr_type a);
        pbcs_pkg::pbcs_addr_type base;
        base = `PBCS_OFS_COMMAND;
        hitsWord = (a[11:2] == base[11:2]);
    endfunction

    // Widens two byte enables into a mask over one 16-bit half.
    function automatic pbcs_pkg::pbcs_word_type laneBits(input logic [1:0] be);
        laneBits = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // Selects the space enable that governs a downstream request.
    function automatic logic spaceOpen(input logic isIo, input pbcs_pkg::pbcs_word_type cmd);
        spaceOpen = isIo ? cmd[`PBCS_CMD_IO] : cmd[`PBCS_CMD_MEM];
    endfunction

    // ----------------------------------------------------------------
    // Error pin synchroniser
    // ----------------------------------------------------------------
    logic [2:0] serrSync;
    logic       serrLevel;
    logic [2:0] next_serrSync;
    logic       next_serrLevel;
    logic       serrAssert;

    always_comb begin
        next_serrSync = {serrSync[1:0], serr_n};
        next_serrLevel = serrLevel;
        if (serrSync[1] == serrSync[2]) begin
            next_serrLevel = serrSync[2];
        end
        serrAssert = serrLevel && !next_serrLevel;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serrSync <= 3'h7;
            serrLevel <= 1'b1;
        end else begin
            serrSync <= next_serrSync;
            serrLevel <= next_serrLevel;
        end
    end

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    logic                    wrHit;
    logic                    rdHit;
    pbcs_pkg::pbcs_word_type cmdWrMask;
    pbcs_pkg::pbcs_word_type stsClear;

    always_comb begin
        wrHit = cfgWrite && hitsWord(cfgAddr);
        rdHit = cfgRead && hitsWord(cfgAddr);
        // Only the writable command fields ever see a write enable.
        cmdWrMask = laneBits(cfgByteEn[1:0]) & `PBCS_CMD_RW_MASK;
        // Status is write-one-to-clear through its two upper lanes.
        stsClear = 16'h0000;
        if (wrHit) begin
            stsClear = laneBits(cfgByteEn[3:2]) & cfgWriteData[31:16];
        end
    end

    // ----------------------------------------------------------------
    // Command register
    // ----------------------------------------------------------------
    pbcs_pkg::pbcs_word_type command;
    pbcs_pkg::pbcs_word_type next_command;

    always_comb begin
        next_command = command;
        if (wrHit) begin
            next_command = (command & ~cmdWrMask) |
                           (cfgWriteData[15:0] & cmdWrMask);
        end
        // Bits outside the writable mask never change from zero.
        next_command = next_command & `PBCS_CMD_RW_MASK;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            command <= `PBCS_CMD_RESET;
        end else begin
            command <= next_command;
        end
    end

    // ----------------------------------------------------------------
    // Request qualification
    // ----------------------------------------------------------------
    logic fwdNow;
    logic poisonedWrFwd;
    logic cplPoison;
    logic sendMsg;

    always_comb begin
        // Every decision uses the command value held before this edge.
        fwdNow = dnReqValid && spaceOpen(dnReqIsIo, command);
        poisonedWrFwd = fwdNow && dnReqIsWrite && dnReqPoisoned;
        cplPoison = cplValid && cplPoisoned;
        sendMsg = serrAssert && command[`PBCS_CMD_SYSERR];
    end

    // ----------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------
    pbcs_pkg::pbcs_word_type status;
    pbcs_pkg::pbcs_word_type next_status;
    pbcs_pkg::pbcs_word_type stsSet;

    always_comb begin
        stsSet = 16'h0000;
        stsSet[`PBCS_STS_DETPAR] = (dnReqValid && dnReqPoisoned) || cplPoison;
        stsSet[`PBCS_STS_MPAR] = command[`PBCS_CMD_PARITY] &&
                                 (cplPoison || poisonedWrFwd);
        stsSet[`PBCS_STS_SIGSERR] = sendMsg;
        // A set in the same cycle as a clear wins, so no event is lost.
        next_status = ((status & ~stsClear) | stsSet) & `PBCS_STS_RW1C_MASK;
        next_status = next_status | `PBCS_STS_FIXED;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status <= `PBCS_STS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    logic [31:0] next_readData;
    logic        next_readValid;

    always_comb begin
        // Unmapped addresses return zero rather than stale data.
        next_readData = 32'h0000_0000;
        if (rdHit) begin
            next_readData = {status, command};
        end
        next_readValid = cfgRead;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfgReadData <= 32'h0000_0000;
            cfgReadValid <= 1'b0;
        end else begin
            cfgReadData <= next_readData;
            cfgReadValid <= next_readValid;
        end
    end

    // ----------------------------------------------------------------
    // Downstream answers
    // ----------------------------------------------------------------
    logic next_dnForward;
    logic next_dnUnsupported;
    logic next_dnPromoteWinv;
    logic next_dnBadParity;

    always_comb begin
        next_dnForward = fwdNow;
        next_dnUnsupported = dnReqValid && !fwdNow;
        next_dnPromoteWinv = fwdNow && !dnReqIsIo && dnReqIsWrite &&
                             command[`PBCS_CMD_WINV];
        // Poison travels on whatever the parity response setting says.
        next_dnBadParity = fwdNow && dnReqPoisoned;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dnForward <= 1'b0;
            dnUnsupported <= 1'b0;
            dnPromoteWinv <= 1'b0;
            dnBadParity <= 1'b0;
        end else begin
            dnForward <= next_dnForward;
            dnUnsupported <= next_dnUnsupported;
            dnPromoteWinv <= next_dnPromoteWinv;
            dnBadParity <= next_dnBadParity;
        end
    end

    // ----------------------------------------------------------------
    // Completion answers
    // ----------------------------------------------------------------
    logic next_cplBadParity;

    always_comb begin
        next_cplBadParity = cplPoison;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cplBadParity <= 1'b0;
        end else begin
            cplBadParity <= next_cplBadParity;
        end
    end

    // ----------------------------------------------------------------
    // Secondary answers
    // ----------------------------------------------------------------
    logic next_secForward;
    logic next_secIgnore;

    always_comb begin
        next_secForward = secReqValid && command[`PBCS_CMD_MASTER];
        next_secIgnore = secReqValid && !command[`PBCS_CMD_MASTER];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            secForward <= 1'b0;
            secIgnore <= 1'b0;
        end else begin
            secForward <= next_secForward;
            secIgnore <= next_secIgnore;
        end
    end

    // ----------------------------------------------------------------
    // Error message
    // ----------------------------------------------------------------
    logic next_errMsgSend;

    always_comb begin
        next_errMsgSend = sendMsg;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            errMsgSend <= 1'b0;
        end else begin
            errMsgSend <= next_errMsgSend;
        end
    end

    // ----------------------------------------------------------------
    // Master level
    // ----------------------------------------------------------------
    logic next_upInitAllow;

    always_comb begin
        // The level follows a write at the same edge the register takes it.
        next_upInitAllow = next_command[`PBCS_CMD_MASTER];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            upInitAllow <= 1'b0;
        end else begin
            upInitAllow <= next_upInitAllow;
        end
    end

endmodule // pbcs_command_status

`default_nettype wire

/* File: dv/pbcs_cs_asserts.sv */
// Checker for the command/status block, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pbcs_cs_asserts (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Configuration access
    input wire logic        cfgWrite,
    input wire logic [11:0] cfgAddr,
    input wire logic [3:0]  cfgByteEn,
    input wire logic [31:0] cfgWriteData,
    input wire logic [31:0] cfgReadData,
    input wire logic        cfgReadValid,
    // Downstream requests and answers
    input wire logic        dnReqValid,
    input wire logic        dnReqIsIo,
    input wire logic        dnReqIsWrite,
    input wire logic        dnReqPoisoned,
    input wire logic        dnForward,
    input wire logic        dnUnsupported,
    input wire logic        dnPromoteWinv,
    input wire logic        dnBadParity,
    // Completions
    input wire logic        cplValid,
    input wire logic        cplPoisoned,
    input wire logic        cplBadParity,
    // Secondary side and levels
    input wire logic        serr_n,
    input wire logic        secReqValid,
    input wire logic        secForward,
    input wire logic        secIgnore,
    input wire logic        errMsgSend,
    input wire logic        upInitAllow
);
    // Shadow of the writable command bits, rebuilt from configuration writes.
    logic [8:0] cmd;
    logic       ok;
    logic       masterBit;
    logic       syserrBit;
    logic       winvExp;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd <= 9'h000;
            winvExp <= 1'b0;
        end else begin
            if (cfgWrite && cfgAddr[11:2] == 10'h001) begin
                if (cfgByteEn[0]) cmd[7:0] <= cfgWriteData[7:0] & 8'h57;
                if (cfgByteEn[1]) cmd[8] <= cfgWriteData[8];
            end
            // A promotion is due only for a forwarded memory write.
            winvExp <= dnReqValid && ok && !dnReqIsIo && dnReqIsWrite && cmd[4];
        end
    end
    assign ok = dnReqIsIo ? cmd[0] : cmd[1];
    assign masterBit = cmd[2];
    assign syserrBit = cmd[8];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_fixed_zero:
    assert property (cfgReadValid && $past(cfgAddr) == 12'h004 |-> (cfgReadData & 32'hfea8) == 0)
        else $error("fixed command bit set");
    chk_space_off:
    assert property (dnReqValid && !ok |=> dnUnsupported && !dnForward) else $error("no UR");
    chk_space_on:
    assert property (dnReqValid && ok |=> dnForward && !dnUnsupported) else $error("no fwd");
    chk_promote_winv:
    assert property (dnPromoteWinv == winvExp) else $error("bad promote");
    chk_dn_parity:
    assert property (dnForward |-> dnBadParity == $past(dnReqPoisoned)) else $error("dn parity");
    chk_cpl_parity:
    assert property (cplValid && cplPoisoned |=> cplBadParity) else $error("cpl parity");
    chk_master_gate:
    assert property (secReqValid |=> secForward == $past(masterBit) &&
                                     secIgnore != $past(masterBit))
        else $error("master gate");
    chk_init_level:
    assert property (upInitAllow == cmd[2]) else $error("init level");
    chk_serr_msg:
    assert property ($fell(serr_n) && cmd[8] |-> ##[3:6] errMsgSend) else $error("no message");
    chk_serr_quiet:
    assert property (errMsgSend |-> $past(syserrBit)) else $error("message while off");
endmodule // pbcs_cs_asserts
bind pbcs_command_status pbcs_cs_asserts u_chk (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .cfgWrite      (cfgWrite),
    .cfgAddr       (cfgAddr),
    .cfgByteEn     (cfgByteEn),
    .cfgWriteData  (cfgWriteData),
    .cfgReadData   (cfgReadData),
    .cfgReadValid  (cfgReadValid),
    .dnReqValid    (dnReqValid),
    .dnReqIsIo     (dnReqIsIo),
    .dnReqIsWrite  (dnReqIsWrite),
    .dnReqPoisoned (dnReqPoisoned),
    .dnForward     (dnForward),
    .dnUnsupported (dnUnsupported),
    .dnPromoteWinv (dnPromoteWinv),
    .dnBadParity   (dnBadParity),
    .cplValid      (cplValid),
    .cplPoisoned   (cplPoisoned),
    .cplBadParity  (cplBadParity),
    .serr_n        (serr_n),
    .secReqValid   (secReqValid),
    .secForward    (secForward),
    .secIgnore     (secIgnore),
    .errMsgSend    (errMsgSend),
    .upInitAllow   (upInitAllow)
);
`default_nettype wire

/* File: dv/pbcs_sec_agent.sv */
// Secondary bus agent that pulls the open-drain system-error line low.
// Assumes a pull-up on the line, so it reads high while released.
`timescale 1ns/1ps
`default_nettype none
module pbcs_sec_agent (
    input wire logic clk_sys,
    input wire logic errKick,
    output logic     serr_n
);
    logic [3:0] hold = 4'h0;
    // The line stays low long enough to pass the input filter.
    always @(posedge clk_sys) begin
        if (errKick) hold <= 4'h6;
        else if (hold != 4'h0) hold <= hold - 4'h1;
    end
    assign serr_n = (hold == 4'h0);
endmodule // pbcs_sec_agent
`default_nettype wire

/* File: dv/pbcs_command_status_bench.sv */
// Self-checking bench for the command/status block.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module pbcs_command_status_bench;
    logic clk_sys = 1'b0, rst = 1'b1, cfgWrite = 1'b0, cfgRead = 1'b0;
    pbcs_pkg::pbcs_addr_type cfgAddr = 12'h000;
    logic [3:0] cfgByteEn = 4'h0;
    logic [31:0] cfgWriteData = 32'h0, cfgReadData;
    logic dnReqValid = 1'b0, dnReqIsIo = 1'b0, dnReqIsWrite = 1'b0, dnReqPoisoned = 1'b0;
    logic cplValid = 1'b0, cplPoisoned = 1'b0, secReqValid = 1'b0, errKick = 1'b0;
    logic cfgReadValid, dnForward, dnUnsupported, dnPromoteWinv, dnBadParity;
    logic cplBadParity, serr_n, secForward, secIgnore, errMsgSend, upInitAllow;
    int err_total = 0, cmp_count = 0, i;
    always #2.5 clk_sys = ~clk_sys;
    pbcs_command_status dut (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .cfgWrite      (cfgWrite),
        .cfgRead       (cfgRead),
        .cfgAddr       (cfgAddr),
        .cfgByteEn     (cfgByteEn),
        .cfgWriteData  (cfgWriteData),
        .cfgReadData   (cfgReadData),
        .cfgReadValid  (cfgReadValid),
        .dnReqValid    (dnReqValid),
        .dnReqIsIo     (dnReqIsIo),
        .dnReqIsWrite  (dnReqIsWrite),
        .dnReqPoisoned (dnReqPoisoned),
        .dnForward     (dnForward),
        .dnUnsupported (dnUnsupported),
        .dnPromoteWinv (dnPromoteWinv),
        .dnBadParity   (dnBadParity),
        .cplValid      (cplValid),
        .cplPoisoned   (cplPoisoned),
        .cplBadParity  (cplBadParity),
        .serr_n        (serr_n),
        .secReqValid   (secReqValid),
        .secForward    (secForward),
        .secIgnore     (secIgnore),
        .errMsgSend    (errMsgSend),
        .upInitAllow   (upInitAllow)
    );
    pbcs_sec_agent agent (.clk_sys(clk_sys), .errKick(errKick), .serr_n(serr_n));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        @(posedge clk_sys);
        {cfgWrite, cfgAddr, cfgByteEn, cfgWriteData} <= {1'b1, 12'h004, be, d};
        @(posedge clk_sys);
        cfgWrite <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        {cfgRead, cfgAddr} <= {1'b1, a};
        @(posedge clk_sys);
        cfgRead <= 1'b0;
        #1 chk({cfgReadValid, 31'h0}, 32'h8000_0000);
        chk(cfgReadData, exp);
    endtask
    task automatic dn(input logic [2:0] k, input logic [3:0] exp);
        @(posedge clk_sys);
        {dnReqValid, dnReqIsIo, dnReqIsWrite, dnReqPoisoned} <= {1'b1, k};
        @(posedge clk_sys);
        dnReqValid <= 1'b0;
        #1 chk(32'({dnForward, dnUnsupported, dnPromoteWinv, dnBadParity}), 32'(exp));
    endtask
    task automatic side(input logic c, input logic [2:0] exp);
        @(posedge clk_sys);
        {cplValid, cplPoisoned, secReqValid} <= {c, c, !c};
        @(posedge clk_sys);
        {cplValid, cplPoisoned, secReqValid} <= 3'h0;
        #1 chk(32'({cplBadParity, secForward, secIgnore}), 32'(exp));
    endtask
    task automatic kick(input logic on);
        int n;
        @(posedge clk_sys);
        errKick <= 1'b1;
        @(posedge clk_sys);
        errKick <= 1'b0;
        for (n = 0; n < 12 && errMsgSend !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(32'(n < 12), 32'(on));
        if (on && n == 12) close_out();
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(12'h004, 32'h0010_0000);
        rd(12'h008, 32'h0);
        wr(4'h3, 32'hffff);
        rd(12'h004, 32'h0010_0157);
        $display("Test registers done");
        for (i = 0; i < 4; i++) begin
            wr(4'h3, 32'h10 | 32'(i));
            dn(3'b110, {i[0], !i[0], 2'b00});
            dn(3'b010, {i[1], !i[1], i[1], 1'b0});
        end
        $display("Test gating done");
        wr(4'h3, 32'h0043);
        dn(3'b011, 4'b1001);
        rd(12'h004, 32'h8110_0043);
        wr(4'hc, 32'hffff_0000);
        wr(4'h3, 32'h0003);
        side(1'b1, 3'b100);
        dn(3'b011, 4'b1001);
        rd(12'h004, 32'h8010_0003);
        wr(4'hc, 32'hffff_0000);
        $display("Test poison done");
        for (i = 0; i < 2; i++) begin
            wr(4'h3, 32'(i * 4));
            #1 chk(32'(upInitAllow), 32'(i));
            side(1'b0, {1'b0, i[0], !i[0]});
        end
        $display("Test master done");
        for (i = 0; i < 2; i++) begin
            wr(4'h3, 32'(i * 256));
            kick(i[0]);
            rd(12'h004, 32'h0010_0000 | 32'(i * 32'h4000_0100));
        end
        $display("Test system error done");
        close_out();
    end
endmodule // pbcs_command_status_bench
`default_nettype wire
